/* File: core/rss_sequencer.sv */
// Reset source sequencer with its reset-sensitive registers
// Rules of the document this block is written to
// RULE_01 - Six reset sources exist; any one of them resets the device.
// RULE_02 - Writing one to the software reset request bit resets the device.
// RULE_03 - Reset pin low holds pins, CPU and registers in reset.
// RULE_04 - On reset pin rising, fetch reset vector and start execution.
// RULE_05 - After any reset, CPU runs from low-speed oscillator divided by eight.
// RULE_06 - No reset clears internal RAM.
// RULE_07 - Outside party holds reset pin low at least 500 us.
// RULE_08 - At power on, pin stays low through supply settle plus 500 us.
// RULE_09 - Power-on release waits 32 low-speed cycles after threshold 1 reached.
// RULE_10 - Monitor 1 resets at or below threshold 1; releases after 32 cycles.
// RULE_11 - Monitor 1 reset stays enabled after power-on reset.
// RULE_12 - Supply at or below threshold 2 resets and restarts from vector.
// RULE_13 - Monitor 2 reset keeps a subset of registers unchanged.
// RULE_14 - Port pins come up as inputs after reset.
// RULE_15 - Compare 0 register resets to all ones in output compare mode.
// RULE_16 - Option function select register ignores program writes.
// RULE_17 - Software leaves reserved register ranges alone.
// RULE_18 - Timer Z prescaler, secondary and primary reset to all ones.
// RULE_19 - Serial control 0 resets to 08h, control 1 to 02h.
// RULE_20 - Watchdog underflow resets only when its select bit is one.
// RULE_21 - Combined reset is released on a low-speed clock tick.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module rss_sequencer
    import rss_pkg::*;
#(
    parameter int LS_DIV = LS_DIV_CYCLES,
    parameter int RELEASE_TICKS = RELEASE_LS_TICKS,
    parameter int CPU_DIV = CPU_LS_DIV,
    parameter logic [7:0] OFS_DEFAULT = 8'hff // Arbitrary value
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic reset_pin_n_in,
    input wire logic supply_above_th1_in,
    input wire logic supply_above_th2_in,
    input wire logic wdt_underflow_in,
    input wire logic [7:0] ofs_flash_in,
    input wire rss_bus_t bus_in,
    output logic [7:0] rdata_out,
    output logic sys_reset_n_out,
    output logic vector_fetch_out,
    output logic cpu_clk_en_out,
    output rss_sfr_t sfr_out
);
    // Elaboration-time refusal of sizes the counters cannot serve
    if (LS_DIV < 2 || RELEASE_TICKS < 1 || CPU_DIV < 1) begin : g_bad_param
        $error("rss_sequencer: bad parameter");
    end

    // ********************
    // Input synchronisers and low-speed divider
    // ********************
    logic [1:0] pin_sync_reg, th1_sync_reg, th2_sync_reg;
    logic [1:0] pin_sync_next, th1_sync_next, th2_sync_next;
    logic [$clog2(LS_DIV)-1:0] ls_cnt_reg, ls_cnt_next;
    logic [$clog2(CPU_DIV+1)-1:0] cpu_cnt_reg, cpu_cnt_next;
    logic ls_tick;

    // Second stage only is read; first stage feeds nothing else
    always_comb begin
        pin_sync_next = {pin_sync_reg[0], reset_pin_n_in};
        th1_sync_next = {th1_sync_reg[0], supply_above_th1_in};
        th2_sync_next = {th2_sync_reg[0], supply_above_th2_in};
        ls_tick = (ls_cnt_reg == ($clog2(LS_DIV))'(LS_DIV - 1));
        ls_cnt_next = ls_tick ? '0 : ls_cnt_reg + 1'b1;
        cpu_cnt_next = cpu_cnt_reg;
        if (!sys_reset_n_out) begin
            cpu_cnt_next = '0;
        end else if (ls_tick) begin
            // CPU clock is the low-speed tick divided by eight
            cpu_cnt_next = (cpu_cnt_reg == ($clog2(CPU_DIV+1))'(CPU_DIV - 1)) ? '0 : cpu_cnt_reg + 1'b1; // RULE_05
        end
    end

    // Pin levels start as "no reset" so power-on alone decides
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pin_sync_reg <= 2'b11;
            th1_sync_reg <= 2'b00;
            th2_sync_reg <= 2'b00;
            ls_cnt_reg <= '0;
            cpu_cnt_reg <= '0;
        end else begin
            pin_sync_reg <= pin_sync_next;
            th1_sync_reg <= th1_sync_next;
            th2_sync_reg <= th2_sync_next;
            ls_cnt_reg <= ls_cnt_next;
            cpu_cnt_reg <= cpu_cnt_next;
        end
    end

    // ********************
    // Reset sequencer
    // ********************
    rss_state_t state_reg, state_next;
    logic [$clog2(RELEASE_TICKS+1)-1:0] rel_cnt_reg, rel_cnt_next;
    logic long_reg, long_next;
    logic hw_reg, hw_next;
    logic rst_n_reg, rst_n_next;
    logic fetch_reg, fetch_next;
    logic cpu_en_reg, cpu_en_next;
    logic [7:0] pm0_reg, pm1_reg, vw1c_reg;
    logic pin_low, th1_low, th2_low, vm1_hit, wdt_hit, sw_hit, level_hit;

    // Source decode; comparators arrive synchronised
    always_comb begin
        pin_low = !pin_sync_reg[1]; // RULE_03
        th1_low = !th1_sync_reg[1];
        th2_low = !th2_sync_reg[1]; // RULE_12
        vm1_hit = th1_low && vw1c_reg[VM1_EN_BIT]; // RULE_10
        wdt_hit = wdt_underflow_in && pm1_reg[WDT_SEL_BIT]; // RULE_20
        sw_hit = bus_in.we && bus_in.addr == ADDR_PM0 && bus_in.wdata[SWRST_BIT]; // RULE_02
        // Power-on stays held until threshold 1 is reached
        level_hit = pin_low || th2_low || vm1_hit || (long_reg && th1_low); // RULE_09
    end

    // Release path: hold, optional 32-tick count, tick-aligned exit
    always_comb begin
        state_next = state_reg;
        rel_cnt_next = rel_cnt_reg;
        long_next = long_reg || vm1_hit;
        hw_next = hw_reg || pin_low;
        unique case (state_reg)
            ST_HOLD: begin
                rel_cnt_next = '0;
                if (!level_hit) begin
                    state_next = long_next ? ST_COUNT : ST_SYNC;
                end
            end
            ST_COUNT: begin
                if (ls_tick) begin
                    rel_cnt_next = rel_cnt_reg + 1'b1;
                    if (rel_cnt_reg == ($clog2(RELEASE_TICKS+1))'(RELEASE_TICKS - 1)) begin
                        state_next = ST_FETCH; // RULE_09 RULE_10
                    end
                end
            end
            ST_SYNC: begin
                if (ls_tick) begin
                    state_next = ST_FETCH; // RULE_21
                end
            end
            ST_FETCH: begin
                state_next = ST_RUN; // RULE_04
                // A cause arriving in this very cycle must not be lost
                long_next = vm1_hit;
                hw_next = pin_low;
            end
            ST_RUN: begin
            end
        endcase
        // Any source pulls back to hold from any state
        if (level_hit || wdt_hit || sw_hit) begin
            state_next = ST_HOLD; // RULE_01
        end
        rst_n_next = (state_next == ST_FETCH) || (state_next == ST_RUN);
        fetch_next = (state_next == ST_FETCH);
        cpu_en_next = ls_tick && sys_reset_n_out && cpu_cnt_reg == '0; // RULE_05
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_HOLD;
            rel_cnt_reg <= '0;
            long_reg <= 1'b1;
            hw_reg <= 1'b0;
            rst_n_reg <= 1'b0;
            fetch_reg <= 1'b0;
            cpu_en_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rel_cnt_reg <= rel_cnt_next;
            long_reg <= long_next;
            hw_reg <= hw_next;
            rst_n_reg <= rst_n_next;
            fetch_reg <= fetch_next;
            cpu_en_reg <= cpu_en_next;
        end
    end

    assign sys_reset_n_out = rst_n_reg;
    assign vector_fetch_out = fetch_reg;
    assign cpu_clk_en_out = cpu_en_reg;

    // ********************
    // Registers
    // ********************
    rss_sfr_t sfr_reg, sfr_next;
    logic [7:0] pm0_next, pm1_next, vw1c_next, tcc1_reg, tcc1_next;
    logic [7:0] ofs_reg, ofs_next, rdata_reg, rdata_next;
    logic run_prev_reg, in_rst;

    // RAM is not held here, so no reset path ever touches it
    always_comb begin
        in_rst = !rst_n_reg; // RULE_06
        pm0_next = pm0_reg;
        pm1_next = pm1_reg;
        vw1c_next = vw1c_reg;
        tcc1_next = tcc1_reg;
        sfr_next = sfr_reg;
        ofs_next = ofs_reg;
        if (in_rst) begin
            pm0_next = BYTE_ZERO;
            pm1_next = BYTE_ZERO;
            tcc1_next = BYTE_ZERO;
            sfr_next.tz_prescale = TZ_RST; // RULE_18
            sfr_next.tz_secondary = TZ_RST;
            sfr_next.tz_primary = TZ_RST;
            sfr_next.ser_ctrl0 = SER_C0_RST; // RULE_19
            sfr_next.ser_ctrl1 = SER_C1_RST;
            sfr_next.pd1 = BYTE_ZERO; // RULE_14
            sfr_next.pd3 = BYTE_ZERO;
            sfr_next.pd4 = BYTE_ZERO;
            // Mode bit is read before it clears, on reset entry only
            if (run_prev_reg) begin
                sfr_next.tm0 = tcc1_reg[OC_MODE_BIT] ? TM0_OC_RST : TM0_RST; // RULE_15
            end
            // Light resets keep monitor 1 setup; power-on sets enable
            if (long_reg) begin
                vw1c_next = VW1C_POR_RST; // RULE_11
            end else if (hw_reg) begin
                vw1c_next = VW1C_HW_RST;
            end // RULE_13
            ofs_next = ofs_flash_in;
        end else if (bus_in.we) begin
            // Option register has no bus write path; only reset loads it from flash
            unique case (bus_in.addr) // RULE_16
                ADDR_PM0: pm0_next = bus_in.wdata & ~(8'h01 << SWRST_BIT);
                ADDR_PM1: pm1_next = bus_in.wdata;
                ADDR_VW1C: vw1c_next = bus_in.wdata;
                ADDR_TCC1: tcc1_next = bus_in.wdata;
                ADDR_TIMER_Z_PRESCALER: sfr_next.tz_prescale = bus_in.wdata;
                ADDR_TIMER_Z_SECONDARY: sfr_next.tz_secondary = bus_in.wdata;
                ADDR_TIMER_Z_PRIMARY: sfr_next.tz_primary = bus_in.wdata;
                ADDR_TM0_LO: sfr_next.tm0[7:0] = bus_in.wdata;
                ADDR_TM0_HI: sfr_next.tm0[15:8] = bus_in.wdata;
                ADDR_SER_C0: sfr_next.ser_ctrl0 = bus_in.wdata;
                ADDR_SER_C1: sfr_next.ser_ctrl1 = bus_in.wdata;
                ADDR_PD1: sfr_next.pd1 = bus_in.wdata;
                ADDR_PD3: sfr_next.pd3 = bus_in.wdata;
                ADDR_PD4: sfr_next.pd4 = bus_in.wdata;
                default: begin
                end
            endcase
        end
        // Unmapped and reserved addresses read as zero
        rdata_next = BYTE_ZERO;
        if (bus_in.re) begin
            unique case (bus_in.addr)
                ADDR_PM0: rdata_next = pm0_reg;
                ADDR_PM1: rdata_next = pm1_reg;
                ADDR_VW1C: rdata_next = vw1c_reg;
                ADDR_TCC1: rdata_next = tcc1_reg;
                ADDR_TIMER_Z_PRESCALER: rdata_next = sfr_reg.tz_prescale;
                ADDR_TIMER_Z_SECONDARY: rdata_next = sfr_reg.tz_secondary;
                ADDR_TIMER_Z_PRIMARY: rdata_next = sfr_reg.tz_primary;
                ADDR_TM0_LO: rdata_next = sfr_reg.tm0[7:0];
                ADDR_TM0_HI: rdata_next = sfr_reg.tm0[15:8];
                ADDR_SER_C0: rdata_next = sfr_reg.ser_ctrl0;
                ADDR_SER_C1: rdata_next = sfr_reg.ser_ctrl1;
                ADDR_PD1: rdata_next = sfr_reg.pd1;
                ADDR_PD3: rdata_next = sfr_reg.pd3;
                ADDR_PD4: rdata_next = sfr_reg.pd4;
                ADDR_OFS: rdata_next = ofs_reg;
                default: rdata_next = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pm0_reg <= BYTE_ZERO;
            pm1_reg <= BYTE_ZERO;
            vw1c_reg <= VW1C_POR_RST;
            tcc1_reg <= BYTE_ZERO;
            // Power-on loads the same reset values as any other reset with compare mode off
            sfr_reg <= '{tm0: TM0_RST, tz_prescale: TZ_RST, tz_secondary: TZ_RST, tz_primary: TZ_RST,
                ser_ctrl0: SER_C0_RST, ser_ctrl1: SER_C1_RST, pd1: BYTE_ZERO, pd3: BYTE_ZERO, pd4: BYTE_ZERO};
            ofs_reg <= OFS_DEFAULT;
            rdata_reg <= BYTE_ZERO;
            run_prev_reg <= 1'b0;
        end else begin
            pm0_reg <= pm0_next;
            pm1_reg <= pm1_next;
            vw1c_reg <= vw1c_next;
            tcc1_reg <= tcc1_next;
            sfr_reg <= sfr_next;
            ofs_reg <= ofs_next;
            rdata_reg <= rdata_next;
            run_prev_reg <= rst_n_reg;
        end
    end

    assign sfr_out = sfr_reg;
    assign rdata_out = rdata_reg;

    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_release;
        !rst_n_reg ##1 rst_n_reg;
    endsequence

    a_pin_holds_reset: assert property (pin_low |=> !rst_n_reg) // RULE_03
        else $error("pin low did not hold reset");
    a_sw_request: assert property (sw_hit |=> !rst_n_reg ##1 !rst_n_reg) // RULE_02
        else $error("software request did not reset");
    a_wdt_select: assert property (wdt_underflow_in && !pm1_reg[WDT_SEL_BIT] && state_reg == ST_RUN
        && !level_hit && !sw_hit |=> state_reg == ST_RUN) // RULE_20
        else $error("unselected watchdog caused reset");
    a_release_tick: assert property (s_release |-> $past(ls_tick)) // RULE_21
        else $error("release not on low-speed tick");
    a_vector_fetch: assert property (s_release |-> fetch_reg ##1 !fetch_reg) // RULE_04
        else $error("no single vector fetch after release");
    a_count_done: assert property (state_reg == ST_COUNT && state_next == ST_FETCH
        |-> rel_cnt_reg == ($clog2(RELEASE_TICKS+1))'(RELEASE_TICKS - 1)) // RULE_09
        else $error("released before full count");
    a_sfr_reset: assert property (!rst_n_reg |=> sfr_reg.pd1 == BYTE_ZERO && sfr_reg.tz_primary == TZ_RST
        && sfr_reg.ser_ctrl0 == SER_C0_RST && sfr_reg.ser_ctrl1 == SER_C1_RST) // RULE_19
        else $error("register reset value wrong");
    a_light_keeps: assert property (!rst_n_reg && !long_reg && !hw_reg |=> $stable(vw1c_reg)) // RULE_13
        else $error("light reset changed monitor 1 setup");
    a_ofs_readonly: assert property (bus_in.we && bus_in.addr == ADDR_OFS && rst_n_reg
        |=> $stable(ofs_reg)) // RULE_16
        else $error("option register took a write");
    a_tm0_oc: assert property (run_prev_reg && !rst_n_reg && tcc1_reg[OC_MODE_BIT]
        |=> sfr_reg.tm0 == TM0_OC_RST) // RULE_15
        else $error("compare 0 not all ones");
endmodule

/* File: core/rss_pkg.sv */
// Shared constants and types of the reset source sequencer
package rss_pkg;
    // ********************
    // Timing
    // ********************
    localparam int CLK_PERIOD_NS = 50;
    localparam int LS_PERIOD_NS = 25000;
    localparam int LS_DIV_CYCLES = LS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int RELEASE_LS_TICKS = 32;
    localparam int CPU_LS_DIV = 8;
    // ********************
    // Register map
    // ********************
    localparam logic [15:0] ADDR_PM0 = 16'h0004;
    localparam logic [15:0] ADDR_PM1 = 16'h0005;
    localparam logic [15:0] ADDR_VW1C = 16'h0036;
    localparam logic [15:0] ADDR_TIMER_Z_PRESCALER = 16'h0085;
    localparam logic [15:0] ADDR_TIMER_Z_SECONDARY = 16'h0086;
    localparam logic [15:0] ADDR_TIMER_Z_PRIMARY = 16'h0087;
    localparam logic [15:0] ADDR_TCC1 = 16'h009b;
    localparam logic [15:0] ADDR_TM0_LO = 16'h009c;
    localparam logic [15:0] ADDR_TM0_HI = 16'h009d;
    localparam logic [15:0] ADDR_SER_C0 = 16'h00a4;
    localparam logic [15:0] ADDR_SER_C1 = 16'h00a5;
    localparam logic [15:0] ADDR_PD1 = 16'h00e3;
    localparam logic [15:0] ADDR_PD3 = 16'h00e7;
    localparam logic [15:0] ADDR_PD4 = 16'h00ea;
    localparam logic [15:0] ADDR_OFS = 16'hffff;
    // ********************
    // Fields and reset values
    // ********************
    localparam int SWRST_BIT = 3;
    localparam int WDT_SEL_BIT = 2;
    localparam int VM1_EN_BIT = 0;
    localparam int OC_MODE_BIT = 3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] TZ_RST = 8'hff;
    localparam logic [7:0] SER_C0_RST = 8'h08;
    localparam logic [7:0] SER_C1_RST = 8'h02;
    localparam logic [7:0] VW1C_HW_RST = 8'h00;
    localparam logic [7:0] VW1C_POR_RST = 8'h41;
    localparam logic [15:0] TM0_OC_RST = 16'hffff;
    localparam logic [15:0] TM0_RST = 16'h0000;
    typedef enum logic [2:0] {ST_HOLD, ST_COUNT, ST_SYNC, ST_FETCH, ST_RUN} rss_state_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } rss_bus_t;
    typedef struct packed {
        logic [15:0] tm0;
        logic [7:0] tz_prescale;
        logic [7:0] tz_secondary;
        logic [7:0] tz_primary;
        logic [7:0] ser_ctrl0;
        logic [7:0] ser_ctrl1;
        logic [7:0] pd1;
        logic [7:0] pd3;
        logic [7:0] pd4;
    } rss_sfr_t;
endpackage

/* File: tb/rss_pin_model.sv */
// External reset circuit driving the active-low reset pin
`timescale 1ns/1ns
module rss_pin_model #(
    parameter int MIN_LOW = 80
) (
    input wire logic clock_in,
    input wire logic hold_req_in,
    output logic reset_pin_n_out
);
    // ********************
    // Pin hold logic
    // ********************
    int low_cnt = 0;
    // Pin starts low so power-up covers supply settle plus the minimum hold
    initial reset_pin_n_out = 1'b0;
    // Every request restarts the hold, so no pulse is ever shorter than MIN_LOW
    always @(posedge clock_in) begin
        if (hold_req_in) begin
            reset_pin_n_out <= 1'b0;
            low_cnt <= 0;
        end else if (low_cnt < MIN_LOW) begin
            low_cnt <= low_cnt + 1;
        end else begin
            reset_pin_n_out <= 1'b1;
        end
    end
endmodule

/* File: tb/tb_rss_sequencer.sv */
// Self-checking bench for the reset source sequencer
`timescale 1ns/1ns
module tb_rss_sequencer;
    import rss_pkg::*;
    // ********************
    // Setup
    // ********************
    localparam int LSD = 4;
    localparam int RT = 4;
    localparam logic [7:0] OFS_VAL = 8'h5a;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic pin_req = 1'b1;
    logic th1 = 1'b1;
    logic th2 = 1'b1;
    logic wdt = 1'b0;
    rss_bus_t bus = '0;
    logic reset_pin_n;
    logic [7:0] rdata;
    logic sys_n;
    logic fetch;
    logic clk_en;
    rss_sfr_t sfr;
    int n_errors = 0;
    int checks_done = 0;
    int n;
    logic [15:0] t_addr [15] = '{ADDR_PM0, ADDR_PM1, ADDR_VW1C, ADDR_TIMER_Z_PRESCALER, ADDR_TIMER_Z_SECONDARY, ADDR_TIMER_Z_PRIMARY, ADDR_TCC1,
        ADDR_TM0_LO, ADDR_TM0_HI, ADDR_SER_C0, ADDR_SER_C1, ADDR_PD1, ADDR_PD3, ADDR_PD4, ADDR_OFS};
    logic [7:0] t_exp [15] = '{8'h00, 8'h00, VW1C_POR_RST, TZ_RST, TZ_RST, TZ_RST, 8'h00, 8'h00, 8'h00,
        SER_C0_RST, SER_C1_RST, 8'h00, 8'h00, 8'h00, OFS_VAL};
    // Free-running system clock
    always #25 clock_in = ~clock_in;
    rss_pin_model #(.MIN_LOW(20 * LSD)) u_rss_pin_model (
        .clock_in(clock_in),
        .hold_req_in(pin_req),
        .reset_pin_n_out(reset_pin_n)
    );
    rss_sequencer #(.LS_DIV(LSD), .RELEASE_TICKS(RT)) u_rss_sequencer (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .reset_pin_n_in(reset_pin_n),
        .supply_above_th1_in(th1),
        .supply_above_th2_in(th2),
        .wdt_underflow_in(wdt),
        .ofs_flash_in(OFS_VAL),
        .bus_in(bus),
        .rdata_out(rdata),
        .sys_reset_n_out(sys_n),
        .vector_fetch_out(fetch),
        .cpu_clk_en_out(clk_en),
        .sfr_out(sfr)
    );
    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Let the edge's updates land before looking
    task automatic step();
        @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_in);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clock_in);
        bus.we <= 1'b0;
    endtask
    // Read data is only valid in the cycle right after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock_in);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clock_in);
        bus.re <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic pulse_wdt();
        @(posedge clock_in);
        wdt <= 1'b1;
        @(posedge clock_in);
        wdt <= 1'b0;
    endtask
    task automatic wait_low();
        for (int i = 0; i < 8 && sys_n !== 1'b0; i++) step();
        chk(sys_n, 1'b0);
    endtask
    task automatic wait_run(output int cyc);
        cyc = 0;
        while (fetch !== 1'b1 && cyc < 400) begin
            step();
            cyc++;
        end
        chk(fetch, 1'b1);
        chk(sys_n, 1'b1);
        step();
        chk(fetch, 1'b0);
    endtask
    task automatic wrap_up();
        $display("Errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ********************
    // Tests
    // ********************
    // Hang guard, far beyond the expected few hundred cycles
    initial begin
        #1000000;
        n_errors++;
        wrap_up();
    end
    initial begin
        step();
        chk(sys_n, 1'b0);
        @(posedge clock_in);
        rst_n_in <= 1'b1;
        pin_req <= 1'b0;
        wr(ADDR_TIMER_Z_PRESCALER, 8'h33);
        wait_run(n);
        for (int i = 0; i < 15; i++) rd(t_addr[i], t_exp[i]);
        wr(ADDR_OFS, 8'h00);
        rd(ADDR_OFS, OFS_VAL);
        // Stimulus keeps to mapped addresses; reserved ranges stay untouched
        rd(ADDR_TIMER_Z_PRIMARY, TZ_RST);
        // CPU clock enable spacing after reset
        for (int i = 0; i < 100 && clk_en !== 1'b1; i++) step();
        n = 0;
        do begin
            step();
            n++;
        end while (clk_en !== 1'b1 && n < 100);
        chk(n, LSD * CPU_LS_DIV);
        // Underflow without the select bit must be ignored
        pulse_wdt();
        repeat (4) step();
        chk(sys_n, 1'b1);
        wr(ADDR_PM1, 8'h04);
        wr(ADDR_VW1C, 8'h40);
        wr(ADDR_TIMER_Z_PRESCALER, 8'h12);
        rd(ADDR_TIMER_Z_PRESCALER, 8'h12);
        pulse_wdt();
        wait_low();
        wait_run(n);
        rd(ADDR_TIMER_Z_PRESCALER, TZ_RST);
        rd(ADDR_VW1C, 8'h40);
        rd(ADDR_PM1, 8'h00);
        // Software request with output compare mode selected
        wr(ADDR_TCC1, 8'h08);
        wr(ADDR_PM0, 8'h08);
        wait_low();
        wait_run(n);
        chk(sfr.tm0, TM0_OC_RST);
        rd(ADDR_PM0, 8'h00);
        // Pin reset: compare mode now off, monitor 1 enable cleared
        @(posedge clock_in);
        pin_req <= 1'b1;
        @(posedge clock_in);
        pin_req <= 1'b0;
        wait_low();
        wait_run(n);
        chk(sfr.tm0, TM0_RST);
        rd(ADDR_VW1C, VW1C_HW_RST);
        // Monitor 1 disabled: a low supply is ignored
        @(posedge clock_in) th1 <= 1'b0;
        repeat (8) step();
        chk(sys_n, 1'b1);
        @(posedge clock_in) th1 <= 1'b1;
        wr(ADDR_VW1C, 8'h01);
        th1 <= 1'b0;
        wait_low();
        repeat (10) step();
        @(posedge clock_in) th1 <= 1'b1;
        wait_run(n);
        chk(n >= (RT - 1) * LSD + 2 && n <= RT * LSD + LSD + 2, 1'b1);
        rd(ADDR_VW1C, VW1C_POR_RST);
        // Monitor 2 leaves the monitor 1 control untouched
        @(posedge clock_in) th2 <= 1'b0;
        wait_low();
        repeat (4) step();
        @(posedge clock_in) th2 <= 1'b1;
        wait_run(n);
        rd(ADDR_VW1C, VW1C_POR_RST);
        wrap_up();
    end
endmodule
